/* rtl/dist_map_pkg.sv */
// constants shared by the distance output mapper
package dist_map_pkg;

  localparam int DIST_W = 16;
  localparam int AOUT_W = 12;
  localparam int DLY_W  = 16;
  localparam int CODE_W = 6;
  localparam int SEL_W  = 3;

  // analog codes: full scale is 10 V or 20 mA
  localparam logic [11:0] AOUT_MAX  = 12'hFFF;
  localparam logic [11:0] VOLT_0V   = 12'h000;
  localparam logic [11:0] VOLT_5V   = 12'h7FF;
  localparam logic [11:0] VOLT_10V  = 12'hFFF;
  localparam logic [11:0] CUR_4MA   = 12'h333;
  localparam logic [11:0] CUR_20MA  = 12'hFFF;

  // factory endpoint distances, plain defaults
  localparam logic [15:0] LO_EP_DFLT = 16'h0000;
  localparam logic [15:0] HI_EP_DFLT = 16'hFFFF;

  // push-button codes
  localparam logic [5:0] TCH_LO_EP   = 6'h04;
  localparam logic [5:0] TCH_HI_EP   = 6'h05;
  localparam logic [5:0] TCH_FACTORY = 6'h11;
  localparam logic [5:0] TCH_V5      = 6'h1E;
  localparam logic [5:0] TCH_V10     = 6'h1F;

  // configuration write selectors
  localparam logic [2:0] CFG_LO_EP = 3'h0;
  localparam logic [2:0] CFG_HI_EP = 3'h1;
  localparam logic [2:0] CFG_V_LO  = 3'h2;
  localparam logic [2:0] CFG_V_HI  = 3'h3;
  localparam logic [2:0] CFG_I_LO  = 3'h4;
  localparam logic [2:0] CFG_I_HI  = 3'h5;

  // forced switch response
  localparam logic [1:0] FRC_HOLD = 2'h0;
  localparam logic [1:0] FRC_ON   = 2'h1;
  localparam logic [1:0] FRC_OFF  = 2'h2;

  // switch output type
  localparam logic [1:0] SW_OFF  = 2'h0;
  localparam logic [1:0] SW_SINK = 2'h1;
  localparam logic [1:0] SW_SRC  = 2'h2;

  // analog status indicator
  localparam logic [1:0] AST_BETWEEN = 2'h0;
  localparam logic [1:0] AST_LOW     = 2'h1;
  localparam logic [1:0] AST_HIGH    = 2'h2;

  // millisecond time base
  localparam int MS_NS          = 1000000;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int MS_CYCLES_DFLT =
    (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : dist_map_pkg

/* rtl/distance_output_mapper.sv */
// distance to analog codes and two delayed switch outputs
`timescale 1ns/1ps

module distance_output_mapper #(
  parameter int MS_CYCLES = dist_map_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  input  wire logic                             meas_valid,
  input  wire logic                             meas_target,
  input  wire logic [dist_map_pkg::DIST_W-1:0]  meas_dist,
  input  wire logic                             sync_slave,
  input  wire logic                             sync_missing,
  input  wire logic                             teach_valid,
  input  wire logic [dist_map_pkg::CODE_W-1:0]  teach_code,
  input  wire logic                             teach_disable,
  input  wire logic                             cfg_wr,
  input  wire logic [dist_map_pkg::SEL_W-1:0]   cfg_sel,
  input  wire logic [dist_map_pkg::DIST_W-1:0]  cfg_data,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  pu_volt,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  pu_cur,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  nt_volt,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  nt_cur,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  ns_volt,
  input  wire logic [dist_map_pkg::AOUT_W-1:0]  ns_cur,
  input  wire logic [dist_map_pkg::DLY_W-1:0]   ns_delay_ms,
  input  wire logic [1:0][dist_map_pkg::DIST_W-1:0] sw_setpoint,
  input  wire logic [1:0][dist_map_pkg::DIST_W-1:0] sw_hyst,
  input  wire logic [1:0][dist_map_pkg::DIST_W-1:0] sw_win_size,
  input  wire logic [1:0]                       sw_window,
  input  wire logic [1:0]                       sw_pol,
  input  wire logic [1:0][dist_map_pkg::DLY_W-1:0]  sw_on_dly,
  input  wire logic [1:0][dist_map_pkg::DLY_W-1:0]  sw_off_dly,
  input  wire logic [1:0][dist_map_pkg::DLY_W-1:0]  sw_nt_dly,
  input  wire logic [1:0][1:0]                  sw_nt_mode,
  input  wire logic [1:0][1:0]                  sw_ns_mode,
  input  wire logic [1:0]                       sw_pu_state,
  input  wire logic [1:0][1:0]                  sw_type,
  input  wire logic [1:0]                       sw_led_alt_en,
  input  wire logic [1:0]                       sw_led_alt,
  output logic [dist_map_pkg::AOUT_W-1:0]       volt_code,
  output logic [dist_map_pkg::AOUT_W-1:0]       isrc_code,
  output logic [dist_map_pkg::AOUT_W-1:0]       isnk_code,
  output logic [1:0]                            analog_stat,
  output logic [dist_map_pkg::DIST_W-1:0]       lo_ep,
  output logic [dist_map_pkg::DIST_W-1:0]       hi_ep,
  output logic [1:0]                            sw_sink_on,
  output logic [1:0]                            sw_src_on,
  output logic [1:0]                            sw_led
);
  import dist_map_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // scaling helper: lo + (hi - lo) * frac / full scale

  function automatic logic [11:0] scale(input logic [11:0] lo,
                                        input logic [11:0] hi,
                                        input logic [11:0] frac);
    logic [23:0] p;
    p = 24'h000000;
    if (hi >= lo) begin
      p = 24'(hi - lo) * 24'(frac);
      scale = lo + 12'(p / 24'(AOUT_MAX));
    end else begin
      p = 24'(lo - hi) * 24'(frac);
      scale = lo - 12'(p / 24'(AOUT_MAX));
    end
  endfunction : scale

  //////////////////////////////////////////////////////////////////////////
  // sync input synchroniser and millisecond tick

  logic        sync_meta_r;
  logic        sync_miss_r;
  logic [31:0] pre_r;
  wire         ms_tick = (pre_r == 32'(MS_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_meta_r <= 1'b0;
      sync_miss_r <= 1'b0;
      pre_r       <= 32'h00000000;
    end else begin
      sync_meta_r <= sync_missing;
      sync_miss_r <= sync_meta_r;
      pre_r       <= ms_tick ? 32'h00000000 : pre_r + 32'h00000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // measurement bookkeeping

  logic              first_done_r;
  logic              lost_r;
  logic [DIST_W-1:0] last_dist_r;
  logic [DLY_W-1:0]  lost_ms_r;
  logic [DLY_W-1:0]  ns_ms_r;
  wire               ns_cond   = sync_slave & sync_miss_r;
  wire               ns_active = ns_cond & (ns_ms_r >= ns_delay_ms);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_done_r <= 1'b0;
      lost_r       <= 1'b0;
      last_dist_r  <= LO_EP_DFLT;
    end else if (meas_valid) begin
      first_done_r <= 1'b1;
      lost_r       <= ~meas_target;
      if (meas_target)
        last_dist_r <= meas_dist;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lost_ms_r <= 16'h0000;
      ns_ms_r   <= 16'h0000;
    end else begin
      if (!lost_r)
        lost_ms_r <= 16'h0000;
      else if (ms_tick && lost_ms_r != 16'hFFFF)
        lost_ms_r <= lost_ms_r + 16'h0001;
      if (!ns_cond)
        ns_ms_r <= 16'h0000;
      else if (ms_tick && ns_ms_r != 16'hFFFF)
        ns_ms_r <= ns_ms_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration: endpoints and analog limits

  logic [AOUT_W-1:0] v_lo_r;
  logic [AOUT_W-1:0] v_hi_r;
  logic [AOUT_W-1:0] i_lo_r;
  logic [AOUT_W-1:0] i_hi_r;
  logic [DIST_W-1:0] lo_ep_r;
  logic [DIST_W-1:0] hi_ep_r;
  wire               teach_ok = teach_valid & ~teach_disable;
  wire [AOUT_W-1:0]  cfg_code = cfg_data[AOUT_W-1:0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lo_ep_r <= LO_EP_DFLT;
      hi_ep_r <= HI_EP_DFLT;
      v_lo_r  <= VOLT_0V;
      v_hi_r  <= VOLT_10V;
      i_lo_r  <= CUR_4MA;
      i_hi_r  <= CUR_20MA;
    end else if (teach_ok && teach_code == TCH_FACTORY) begin
      lo_ep_r <= LO_EP_DFLT;
      hi_ep_r <= HI_EP_DFLT;
      v_lo_r  <= VOLT_0V;
      v_hi_r  <= VOLT_10V;
      i_lo_r  <= CUR_4MA;
      i_hi_r  <= CUR_20MA;
    end else if (teach_ok && teach_code == TCH_LO_EP) begin
      lo_ep_r <= last_dist_r;
    end else if (teach_ok && teach_code == TCH_HI_EP) begin
      hi_ep_r <= last_dist_r;
    end else if (teach_ok && teach_code == TCH_V5) begin
      v_lo_r  <= VOLT_0V;
      v_hi_r  <= VOLT_5V;
    end else if (teach_ok && teach_code == TCH_V10) begin
      v_lo_r  <= VOLT_0V;
      v_hi_r  <= VOLT_10V;
    end else if (cfg_wr) begin
      unique case (cfg_sel)
        CFG_LO_EP: lo_ep_r <= cfg_data;
        CFG_HI_EP: hi_ep_r <= cfg_data;
        CFG_V_LO:  v_lo_r  <= cfg_code;
        CFG_V_HI:  v_hi_r  <= cfg_code;
        CFG_I_LO:  i_lo_r  <= cfg_code;
        CFG_I_HI:  i_hi_r  <= cfg_code;
        default: ;
      endcase
    end
  end

  assign lo_ep = lo_ep_r;
  assign hi_ep = hi_ep_r;

  //////////////////////////////////////////////////////////////////////////
  // shared position fraction between the endpoints

  wire              rising = (lo_ep_r <= hi_ep_r);
  wire [DIST_W-1:0] ep_near = rising ? lo_ep_r : hi_ep_r;
  wire [DIST_W-1:0] ep_far  = rising ? hi_ep_r : lo_ep_r;
  wire [DIST_W-1:0] d_clamp = (meas_dist < ep_near) ? ep_near :
                              (meas_dist > ep_far)  ? ep_far  : meas_dist;
  wire [DIST_W-1:0] span    = ep_far - ep_near;
  wire [DIST_W-1:0] pos     = d_clamp - ep_near;
  wire [27:0]       num     = 28'(pos) * 28'(AOUT_MAX);
  wire [27:0]       quo     = (span == 16'h0000) ? 28'h0000000
                                                 : num / 28'(span);
  wire [11:0]       frac_up = quo[11:0];
  wire [11:0]       frac    = rising ? frac_up
                                     : AOUT_MAX - frac_up;

  //////////////////////////////////////////////////////////////////////////
  // analog outputs

  logic [AOUT_W-1:0] frac_r;
  logic [AOUT_W-1:0] volt_r;
  logic [AOUT_W-1:0] cur_r;
  logic [1:0]        stat_r;
  wire  [AOUT_W-1:0] volt_lin = scale(v_lo_r, v_hi_r, frac_r);
  wire  [AOUT_W-1:0] cur_lin  = scale(i_lo_r, i_hi_r, frac_r);
  wire  [AOUT_W-1:0] volt_nxt = !first_done_r ? pu_volt  :
                                ns_active     ? ns_volt  :
                                lost_r        ? nt_volt  :
                                volt_lin;
  wire  [AOUT_W-1:0] cur_nxt  = !first_done_r ? pu_cur   :
                                ns_active     ? ns_cur   :
                                lost_r        ? nt_cur   :
                                cur_lin;
  wire  [1:0]        stat_nxt = (volt_nxt == v_hi_r) ? AST_HIGH :
                                (volt_nxt == v_lo_r) ? AST_LOW  :
                                AST_BETWEEN;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      frac_r <= 12'h000;
    else if (meas_valid && meas_target)
      frac_r <= frac;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      volt_r <= VOLT_0V;
      cur_r  <= CUR_4MA;
      stat_r <= AST_BETWEEN;
    end else begin
      volt_r <= volt_nxt;
      cur_r  <= cur_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign volt_code   = volt_r;
  assign isrc_code   = cur_r;
  assign isnk_code   = cur_r;
  assign analog_stat = stat_r;

  //////////////////////////////////////////////////////////////////////////
  // switch outputs

  for (genvar i = 0; i < 2; i++) begin : g_sw
    logic             cand_r;
    logic             st_r;
    logic             sink_r;
    logic             src_r;
    logic             led_r;
    logic [DLY_W-1:0] dly_r;
    wire  [16:0] d17      = {1'b0, meas_dist};
    wire  [16:0] sp17     = {1'b0, sw_setpoint[i]};
    wire  [16:0] hy17     = {1'b0, sw_hyst[i]};
    wire  [16:0] win_far  = sp17 + {1'b0, sw_win_size[i]};
    wire         in_win   = (d17 >= sp17) && (d17 <= win_far);
    wire         win_st   = in_win ? sw_pol[i] : ~sw_pol[i];
    wire         on_near  = (d17 <= sp17);
    wire         off_near = (d17 > sp17 + hy17);
    wire         on_far   = (d17 >= sp17);
    wire         off_far  = (d17 + hy17 < sp17);
    wire         hys_st   = !sw_pol[i]
                            ? (on_near ? 1'b1 : off_near ? 1'b0 : cand_r)
                            : (on_far  ? 1'b1 : off_far  ? 1'b0 : cand_r);
    wire         cand_nxt = sw_window[i] ? win_st : hys_st;
    wire         cand_upd = meas_valid & meas_target;
    wire         cand_chg = cand_upd & (cand_nxt != cand_r);
    wire [DLY_W-1:0] need = cand_r ? sw_on_dly[i] : sw_off_dly[i];
    wire         dly_met  = (cand_r != st_r) && (dly_r >= need);
    wire         nt_act   = lost_r & (lost_ms_r >= sw_nt_dly[i]);
    wire [1:0]   frc_mode = ns_active ? sw_ns_mode[i] : sw_nt_mode[i];
    wire         frc_st   = (frc_mode == FRC_ON)  ? 1'b1 :
                            (frc_mode == FRC_OFF) ? 1'b0 : st_r;
    wire         st_nxt   = !first_done_r       ? sw_pu_state[i] :
                            (ns_active | nt_act) ? frc_st :
                            lost_r               ? st_r   :
                            dly_met              ? cand_r : st_r;
    wire         on_type  = (sw_type[i] != SW_OFF);

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        cand_r <= 1'b0;
        st_r   <= 1'b0;
      end else begin
        if (cand_upd)
          cand_r <= cand_nxt;
        st_r <= st_nxt;
      end
    end

    // condition must hold unbroken; any flip of the candidate restarts
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
        dly_r <= 16'h0000;
      else if (cand_r == st_r || cand_chg)
        dly_r <= 16'h0000;
      else if (ms_tick && dly_r != 16'hFFFF)
        dly_r <= dly_r + 16'h0001;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        sink_r <= 1'b0;
        src_r  <= 1'b0;
        led_r  <= 1'b0;
      end else begin
        sink_r <= st_nxt & (sw_type[i] == SW_SINK);
        src_r  <= st_nxt & (sw_type[i] == SW_SRC);
        led_r  <= on_type & (sw_led_alt_en[i] ? sw_led_alt[i]
                                              : st_nxt);
      end
    end

    assign sw_sink_on[i] = sink_r;
    assign sw_src_on[i]  = src_r;
    assign sw_led[i]     = led_r;
  end

endmodule : distance_output_mapper

/* bench/dist_map_checker.sv */
// port assertions for the distance output mapper
`timescale 1ns/1ps

module dist_map_checker
  import dist_map_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            nrst,
  input wire logic            meas_valid,
  input wire logic            meas_target,
  input wire logic [15:0]     meas_dist,
  input wire logic            sync_slave,
  input wire logic            teach_valid,
  input wire logic [5:0]      teach_code,
  input wire logic            teach_disable,
  input wire logic            cfg_wr,
  input wire logic [11:0]     pu_volt,
  input wire logic [1:0][1:0] sw_type,
  input wire logic [1:0]      sw_led_alt_en,
  input wire logic [11:0]     volt_code,
  input wire logic [11:0]     isrc_code,
  input wire logic [11:0]     isnk_code,
  input wire logic [15:0]     lo_ep,
  input wire logic [15:0]     hi_ep,
  input wire logic [1:0]      sw_sink_on,
  input wire logic [1:0]      sw_src_on,
  input wire logic [1:0]      sw_led
);
  logic [15:0] last_d_r;
  logic        seen_r;
  wire         quiet = !meas_valid && !teach_valid && !cfg_wr;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // last distance seen with a target, and first measurement flag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_d_r <= 16'h0000;
      seen_r   <= 1'b0;
    end else if (meas_valid) begin
      seen_r <= 1'b1;
      if (meas_target) last_d_r <= meas_dist;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_sink_mirror:
    assert property (isnk_code == isrc_code)
    else $error("sinking loop code differs from sourcing loop");
  a_drive_excl:
    assert property ((sw_sink_on & sw_src_on) == 2'h0)
    else $error("switch drives sinking and sourcing together");
  a_type_off:
    assert property (sw_type[1] == SW_OFF && $past(sw_type[1]) == SW_OFF
      |-> !sw_sink_on[1] && !sw_src_on[1])
    else $error("switch of type off is driven");
  a_led_follow:
    assert property (!sw_led_alt_en[0] && sw_type[0] != SW_OFF
      |-> sw_led[0] == (sw_sink_on[0] || sw_src_on[0]))
    else $error("indicator differs from switch state");
  a_factory_ep:
    assert property (teach_valid && !teach_disable
      && teach_code == TCH_FACTORY
      |=> lo_ep == LO_EP_DFLT && hi_ep == HI_EP_DFLT)
    else $error("factory code did not restore endpoints");
  a_teach_block:
    assert property (teach_valid && teach_disable && !cfg_wr
      |=> $stable(lo_ep) && $stable(hi_ep))
    else $error("blocked push-button code changed endpoints");
  a_lo_capture:
    assert property (teach_valid && !teach_disable && !meas_valid
      && teach_code == TCH_LO_EP |=> lo_ep == last_d_r)
    else $error("low endpoint not taken from last target distance");
  a_pu_hold:
    assert property (!seen_r && $past(nrst) |-> volt_code == pu_volt)
    else $error("voltage left power-up value before measurement");
  a_meas_paced:
    assert property (!sync_slave && $past(nrst) && $past(nrst, 2)
      && $past(quiet) && $past(quiet, 2) |-> $stable(volt_code))
    else $error("voltage changed without a measurement");
endmodule : dist_map_checker

bind distance_output_mapper dist_map_checker chk_u (.*);

/* bench/user_equip_model.sv */
// user equipment: reads the two switch wires
`timescale 1ns/1ps

module user_equip_model (
  input  wire logic [1:0] sw_sink_on,
  input  wire logic [1:0] sw_src_on,
  output logic      [1:0] sw_level
);
  // wire 0 has a pull-up, wire 1 a pull-down to ground
  assign sw_level[0] = sw_sink_on[0] ? 1'b0 : 1'b1;
  assign sw_level[1] = sw_sink_on[1] ? 1'b0 : sw_src_on[1];
endmodule : user_equip_model

/* bench/test_distance_output_mapper.sv */
// self-checking bench for the distance output mapper
`timescale 1ns/1ps

module test_distance_output_mapper;
  import dist_map_pkg::*;
  logic sys_clk = 0, nrst = 0, meas_valid = 0, meas_target = 1;
  logic sync_slave = 0, sync_missing = 1, teach_valid = 0;
  logic teach_disable = 0, cfg_wr = 0, s0 = 0, s1;
  logic [15:0] meas_dist = 0, cfg_data = 0, ns_delay_ms = 0;
  logic [5:0]  teach_code = 0;
  logic [2:0]  cfg_sel = 0;
  logic [11:0] pu_volt = 'h123, pu_cur = 'h456, nt_volt = 'h0AB;
  logic [11:0] nt_cur = 'h0CD, ns_volt = 'h321, ns_cur = 'h654;
  logic [1:0][15:0] sw_setpoint = {16'd3000, 16'd2000};
  logic [1:0][15:0] sw_hyst = {16'd0, 16'd100};
  logic [1:0][15:0] sw_win_size = {16'd500, 16'd0};
  logic [1:0][15:0] sw_on_dly = 0, sw_off_dly = 0, sw_nt_dly = 0;
  logic [1:0][1:0]  sw_nt_mode = 0, sw_ns_mode = 0;
  logic [1:0][1:0]  sw_type = {SW_SRC, SW_SINK};
  logic [1:0]  sw_window = 2'b10, sw_pol = 2'b10, sw_pu_state = 2'b10;
  logic [1:0]  sw_led_alt_en = 0, sw_led_alt = 0;
  logic [11:0] volt_code, isrc_code, isnk_code;
  logic [1:0]  analog_stat, sw_sink_on, sw_src_on, sw_led, sw_level;
  logic [15:0] lo_ep, hi_ep;
  int n_errors = 0, samples_checked = 0, cyc = 0, a, b, d, e;

  distance_output_mapper #(.MS_CYCLES(4)) dut_u (.*);
  user_equip_model equip_u (.*);

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic meas(int dd, logic t);
    @(negedge sys_clk);
    meas_valid = 1'b1;
    meas_dist = dd[15:0];
    meas_target = t;
    @(negedge sys_clk);
    meas_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : meas

  task automatic teach(logic [5:0] c);
    @(negedge sys_clk);
    teach_valid = 1'b1;
    teach_code = c;
    @(negedge sys_clk);
    teach_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : teach

  task automatic cfg(logic [2:0] s, int v);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_sel = s;
    cfg_data = v[15:0];
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : cfg

  // expected analog code from distance, endpoints and output limits
  function automatic int lin(int dd, int lo, int hi, int ol, int oh);
    int n = lo < hi ? lo : hi;
    int f = lo < hi ? hi : lo;
    int fr = (f == n || dd <= n) ? 0 : dd >= f ? 4095
           : (dd - n) * 4095 / (f - n);
    if (lo > hi) fr = 4095 - fr;
    return ol + (oh - ol) * fr / 4095;
  endfunction : lin

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(24514));
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("volt", volt_code, pu_volt);
    chk("isrc", isrc_code, pu_cur);
    chk("sw", sw_level, 2'b11);
    cfg(CFG_V_LO, 'h100);
    cfg(CFG_I_LO, 'h200);
    for (int r = 0; r < 2; r++) begin
      a = r ? 5000 : 1000;
      b = r ? 1000 : 5000;
      sw_pol = r ? 2'b01 : 2'b10;
      cfg(CFG_LO_EP, a);
      cfg(CFG_HI_EP, b);
      for (int i = 0; i < 16; i++) begin
        d = i < 2 ? 995 + 4013 * i : 10 * $urandom_range(0, 600) + 3;
        meas(d, 1'b1);
        e = lin(d, a, b, 'h100, 'hFFF);
        chk("volt", volt_code, e);
        chk("isrc", isrc_code, lin(d, a, b, 'h200, 'hFFF));
        chk("stat", analog_stat, e == 'hFFF ? AST_HIGH
          : e == 'h100 ? AST_LOW : AST_BETWEEN);
        if (sw_pol[0] ? d >= 2000 : d <= 2000) s0 = 1'b1;
        else if (sw_pol[0] ? d < 1900 : d > 2100) s0 = 1'b0;
        s1 = (d >= 3000 && d <= 3500) == sw_pol[1];
        chk("sw", sw_level, {s1, !s0});
      end
    end
    sw_pol = 2'b10;
    meas(3000, 1'b1);
    teach(TCH_LO_EP);
    chk("lo_ep", lo_ep, 16'd3000);
    meas(4000, 1'b1);
    teach(TCH_HI_EP);
    chk("hi_ep", hi_ep, 16'd4000);
    teach_disable = 1'b1;
    meas(1234, 1'b1);
    teach(TCH_FACTORY);
    chk("lo_ep", lo_ep, 16'd3000);
    teach_disable = 1'b0;
    for (int k = 0; k < 2; k++) begin
      teach(k ? TCH_V10 : TCH_V5);
      meas(4003, 1'b1);
      chk("volt", volt_code, k ? 'hFFF : 'h7FF);
    end
    teach(TCH_FACTORY);
    chk("hi_ep", hi_ep, 16'hFFFF);
    meas(30003, 1'b1);
    chk("isrc", isrc_code, lin(30003, 0, 65535, 'h333, 'hFFF));
    meas(2503, 1'b1);
    sw_on_dly[0] = 16'd3;
    sw_off_dly[0] = 16'd3;
    meas(1503, 1'b1);
    chk("sw0", sw_level[0], 1'b1);
    repeat (20) @(negedge sys_clk);
    chk("sw0", sw_level[0], 1'b0);
    meas(2503, 1'b1);
    meas(1503, 1'b1);
    repeat (20) @(negedge sys_clk);
    chk("sw0", sw_level[0], 1'b0);
    sw_on_dly[0] = 16'd0;
    sw_off_dly[0] = 16'd0;
    sw_nt_mode[0] = FRC_OFF;
    sw_nt_dly[0] = 16'd2;
    meas(0, 1'b0);
    chk("volt", volt_code, nt_volt);
    chk("isrc", isrc_code, nt_cur);
    chk("sw0", sw_level[0], 1'b0);
    repeat (20) @(negedge sys_clk);
    chk("sw0", sw_level[0], 1'b1);
    meas(2503, 1'b1);
    sw_nt_mode[0] = FRC_ON;
    sw_nt_dly[0] = 16'd0;
    meas(0, 1'b0);
    chk("sw0", sw_level[0], 1'b0);
    sw_type[1] = SW_OFF;
    sw_led_alt_en[1] = 1'b1;
    sw_led_alt[1] = 1'b1;
    meas(3203, 1'b1);
    chk("sw1", {sw_level[1], sw_led[1]}, 2'b00);
    sw_type[1] = SW_SRC;
    meas(2003, 1'b1);
    chk("sw1", {sw_level[1], sw_led[1]}, 2'b01);
    sw_ns_mode[0] = FRC_OFF;
    ns_delay_ms = 16'd1;
    sync_slave = 1'b1;
    repeat (20) @(negedge sys_clk);
    meas(1503, 1'b1);
    chk("volt", volt_code, ns_volt);
    chk("sw0", sw_level[0], 1'b1);
    sync_missing = 1'b0;
    meas(1503, 1'b1);
    chk("volt", volt_code, lin(1503, 0, 65535, 0, 'hFFF));
    chk("sw0", sw_level[0], 1'b0);
    test_done();
  end
endmodule : test_distance_output_mapper
